// ---- verilog/lhci_map.svh ----
`ifndef LHCI_MAP_SVH
`define LHCI_MAP_SVH
// column counter limits and reset values
`define LHCI_SEG_COUNT 80
`define LHCI_COL_LAST 7'h4f
`define LHCI_COL_STOP 7'h50
`define LHCI_COL_RST 7'h00
`define LHCI_PAGE_RST 2'h3
`define LHCI_LINE_RST 5'h00
// timing: init period and post-write busy window
`define LHCI_CLK_PERIOD_NS 8
`define LHCI_RESET_TIME_NS 1000
`define LHCI_RESET_CYCLES ((`LHCI_RESET_TIME_NS + `LHCI_CLK_PERIOD_NS - 1) / `LHCI_CLK_PERIOD_NS)
`define LHCI_OP_BUSY_CYCLES 2
// command codes, compared against the upper bits shown
`define LHCI_CMD_DISP 7'h57
`define LHCI_CMD_ADC 7'h50
`define LHCI_CMD_STATIC 7'h52
`define LHCI_CMD_DUTY 7'h54
`define LHCI_CMD_LINE 3'h6
`define LHCI_CMD_PAGE 6'h2e
`define LHCI_CMD_RMW 8'he0
`define LHCI_CMD_END 8'hee
`define LHCI_CMD_RESET 8'he2
`endif

// ---- verilog/lhci_pkg.sv ----
package lhci_pkg;
	// one decoded host access
	typedef struct packed {
		logic is_data; // register_select level
		logic is_read; // direction of the cycle
		logic [7:0] data; // write data seen on the bus
	} lhci_cycle_t;
	// status byte layout, msb first
	typedef struct packed {
		logic busy;
		logic seg_order;
		logic disp_off;
		logic resetting;
		logic [3:0] zero;
	} lhci_status_t;
	// host access phase
	typedef enum logic {LHCI_IDLE, LHCI_ACTIVE} lhci_phase_t;
endpackage

// ---- verilog/lhci_bus_sync.sv ----
`timescale 1ns/100ps
module lhci_bus_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// raw host pins
	input wire logic reset_pin,
	input wire logic strobe_e_rd,
	input wire logic dir_rw_wr,
	input wire logic register_select,
	input wire logic [7:0] host_data_in,
	// decoded access
	output logic mode_68,
	output logic pin_edge,
	output logic acc_start,
	output logic acc_end,
	output lhci_pkg::lhci_cycle_t cyc
);
	logic [2:0] pin_sy; // [0] meta, [1] sync, [2] edge history
	logic [1:0] e_sy; // strobe e / rd
	logic [1:0] rw_sy; // direction rw / wr
	logic active; // access in progress
	logic is_read; // direction of that access
	lhci_pkg::lhci_phase_t phase;

	// two-flop synchronisers; the strobes reset high so no false access in 80 mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sy <= 3'h0;
			e_sy <= 2'h3;
			rw_sy <= 2'h3;
		end else begin
			pin_sy <= {pin_sy[1:0], reset_pin};
			e_sy <= {e_sy[0], strobe_e_rd};
			rw_sy <= {rw_sy[0], dir_rw_wr};
		end
	end

	// pin level picks the strobe style, its edges ask for an init
	assign mode_68 = pin_sy[1];
	assign pin_edge = pin_sy[2] ^ pin_sy[1];
	assign active = mode_68 ? e_sy[1] : (~e_sy[1] | ~rw_sy[1]);
	assign is_read = mode_68 ? rw_sy[1] : ~e_sy[1];

	// frame each access: start pulse, data tracking, end pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= lhci_pkg::LHCI_IDLE;
			acc_start <= 1'b0;
			acc_end <= 1'b0;
			cyc <= '0;
		end else begin
			acc_start <= 1'b0;
			acc_end <= 1'b0;
			unique case (phase)
				lhci_pkg::LHCI_IDLE: begin
					if (active) begin
						phase <= lhci_pkg::LHCI_ACTIVE;
						acc_start <= 1'b1;
						cyc <= '{is_data: register_select, is_read: is_read, data: host_data_in};
					end
				end
				lhci_pkg::LHCI_ACTIVE: begin
					if (active) begin
						cyc.data <= host_data_in; // last value before the end wins
					end else begin
						phase <= lhci_pkg::LHCI_IDLE;
						acc_end <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule // lhci_bus_sync

// ---- verilog/lhci_ram.sv ----
`timescale 1ns/100ps
module lhci_ram #(
	parameter int DEPTH = 320,
	parameter int AW = 9
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// host-side read port
	input wire logic [AW-1:0] raddr_a,
	output logic [7:0] rdata_a,
	// panel scan read port
	input wire logic [AW-1:0] raddr_b,
	output logic [7:0] rdata_b
);
	logic [7:0] mem [DEPTH]; // display data, no reset: contents survive init

	// single write port
	always_ff @(posedge clk) begin
		if (we && waddr < AW'(DEPTH)) begin
			mem[waddr] <= wdata;
		end
	end

	// out-of-range reads give zero rather than x
	assign rdata_a = (raddr_a < AW'(DEPTH)) ? mem[raddr_a] : 8'h00;
	assign rdata_b = (raddr_b < AW'(DEPTH)) ? mem[raddr_b] : 8'h00;
endmodule // lhci_ram

// ---- verilog/lhci_top.sv ----
`timescale 1ns/100ps
`include "lhci_map.svh"
// Function
// [RULE1] status: busy, order, off, reset, zeros
// [RULE2] busy while executing or resetting
// [RULE3] host waits for busy low
// [RULE4] order flag 0 inverts columns
// [RULE5] status shows display off as one
// [RULE6] reset flag high through any init
// [RULE7] data write stores, column advances
// [RULE8] data read returns, advances unless rmw
// [RULE9] writes pass through the bus holder
// [RULE10] host dummy-reads after address or write
// [RULE11] host inserts nops if too fast
// [RULE12] static drive forces commons, display on
// [RULE13] off plus static enters power save
// [RULE14] display on or static off exits
// [RULE15] rmw: writes advance, reads hold column
// [RULE16] end leaves rmw, restores column
// [RULE17] host avoids column set during rmw
// [RULE18] reset command: line zero, page three
// [RULE19] host uses pin at power-up
// [RULE20] reset pin level picks bus style
// [RULE21] select and direction decode cycles
// [RULE22] column stops at 50h, page fixed
// [RULE23] pin init restores all defaults
// [RULE24] strobes synchronised before use
// [RULE25] seven-bit column, two-bit page
module lhci_top #(
	parameter int COLS = `LHCI_SEG_COUNT,
	parameter int INIT_CYCLES = `LHCI_RESET_CYCLES,
	parameter int OP_CYCLES = `LHCI_OP_BUSY_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host bus pins
	input wire logic reset_pin,
	input wire logic strobe_e_rd,
	input wire logic dir_rw_wr,
	input wire logic register_select,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_n,
	output logic bus_mode_68,
	// panel scan
	input wire logic [4:0] scan_line,
	input wire logic [6:0] scan_seg,
	output logic seg_bit,
	output logic com_all_active,
	output logic duty_32,
	// power save
	output logic drivers_at_supply,
	output logic oscillator_output_oe_n
);
	localparam int AW = $clog2(4 * COLS);
	localparam int IW = $clog2(INIT_CYCLES + 1);
	localparam int OW = $clog2(OP_CYCLES + 1);

	// ram index of a page and column
	function automatic logic [AW-1:0] ram_idx(input logic [1:0] pg, input logic [6:0] cl);
		ram_idx = AW'(pg) * AW'(COLS) + AW'(cl);
	endfunction

	// saturating column step
	function automatic logic [6:0] next_col(input logic [6:0] cl);
		next_col = (cl < `LHCI_COL_STOP) ? cl + 7'h01 : cl;
	endfunction

	logic mode_68, pin_edge, acc_start, acc_end; // from the synchroniser
	lhci_pkg::lhci_cycle_t cyc; // captured access
	logic cmd_end, wr_end, rd_end; // completed accesses
	logic st_start, rd_start; // read starts
	logic [7:0] cmd; // command byte alias
	logic [6:0] col_reg, saved_col_reg; // column counter and rmw anchor
	logic [1:0] page_reg;
	logic [4:0] line_reg; // display start line
	logic disp_on_reg, static_reg, seg_order_reg, duty_reg, rmw_reg;
	logic [7:0] holder_reg; // bus holder
	logic wr_pend_reg; // holder awaiting commit
	logic [AW-1:0] wr_addr_reg;
	logic [OW-1:0] busy_cnt_reg;
	logic [IW-1:0] init_cnt_reg;
	logic resetting_reg, ps_reg;
	logic busy;
	lhci_pkg::lhci_status_t status;
	logic [7:0] rdata_a, rdata_b;
	logic [4:0] eff_line; // ram line under scan
	logic [6:0] scan_col;

	// strobes are resynchronised before anything acts on them
	lhci_bus_sync u_sync ( // [RULE24]
		.clk(clk),
		.rst_n(rst_n),
		.reset_pin(reset_pin),
		.strobe_e_rd(strobe_e_rd),
		.dir_rw_wr(dir_rw_wr),
		.register_select(register_select),
		.host_data_in(host_data_in),
		.mode_68(mode_68),
		.pin_edge(pin_edge),
		.acc_start(acc_start),
		.acc_end(acc_end),
		.cyc(cyc)
	);

	// cycle kind from select and direction
	assign cmd = cyc.data;
	assign cmd_end = acc_end & ~cyc.is_data & ~cyc.is_read; // [RULE21]
	assign wr_end = acc_end & cyc.is_data & ~cyc.is_read; // [RULE21]
	assign rd_end = acc_end & cyc.is_data & cyc.is_read; // [RULE21]
	assign st_start = acc_start & ~cyc.is_data & cyc.is_read; // [RULE21]
	assign rd_start = acc_start & cyc.is_data & cyc.is_read;

	// status byte assembly
	assign busy = resetting_reg | (busy_cnt_reg != '0) | wr_pend_reg; // [RULE2]
	assign status = '{busy: busy, seg_order: seg_order_reg, // [RULE1]
		disp_off: ~disp_on_reg, resetting: resetting_reg, zero: 4'h0}; // [RULE5]

	lhci_ram #(.DEPTH(4 * COLS), .AW(AW)) u_ram (
		.clk(clk),
		.we(wr_pend_reg),
		.waddr(wr_addr_reg),
		.wdata(holder_reg),
		.raddr_a(ram_idx(page_reg, col_reg)),
		.rdata_a(rdata_a),
		.raddr_b(ram_idx(eff_line[4:3], scan_col)),
		.rdata_b(rdata_b)
	);

	// bus style follows the pin level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_mode_68 <= 1'b0;
		end else begin
			bus_mode_68 <= mode_68; // [RULE20]
		end
	end

	// init period: pin edge or reset command; power-on starts one too
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_reg <= IW'(INIT_CYCLES);
			resetting_reg <= 1'b1;
		end else if (pin_edge || (cmd_end && cmd == `LHCI_CMD_RESET)) begin
			init_cnt_reg <= IW'(INIT_CYCLES); // [RULE6]
			resetting_reg <= 1'b1;
		end else if (init_cnt_reg != '0) begin
			init_cnt_reg <= init_cnt_reg - 1'b1;
			resetting_reg <= (init_cnt_reg != IW'(1)); // [RULE6]
		end else begin
			resetting_reg <= 1'b0;
		end
	end

	// short busy window after every write access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_reg <= '0;
		end else if (acc_end && !cyc.is_read) begin
			busy_cnt_reg <= OW'(OP_CYCLES); // [RULE2]
		end else if (busy_cnt_reg != '0) begin
			busy_cnt_reg <= busy_cnt_reg - 1'b1;
		end
	end

	// mode registers: display, order, static, duty, start line, page, rmw
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n || pin_edge) begin
			disp_on_reg <= 1'b0; // [RULE23]
			line_reg <= `LHCI_LINE_RST;
			static_reg <= 1'b0;
			page_reg <= `LHCI_PAGE_RST;
			duty_reg <= 1'b1;
			seg_order_reg <= 1'b0;
			rmw_reg <= 1'b0;
			saved_col_reg <= `LHCI_COL_RST;
		end else if (cmd_end) begin
			if (cmd[7:1] == `LHCI_CMD_DISP) begin
				disp_on_reg <= cmd[0]; // [RULE14]
			end else if (cmd[7:1] == `LHCI_CMD_ADC) begin
				seg_order_reg <= ~cmd[0]; // [RULE4]
			end else if (cmd[7:1] == `LHCI_CMD_STATIC) begin
				static_reg <= cmd[0]; // [RULE14]
			end else if (cmd[7:1] == `LHCI_CMD_DUTY) begin
				duty_reg <= cmd[0];
			end else if (cmd[7:5] == `LHCI_CMD_LINE) begin
				line_reg <= cmd[4:0];
			end else if (cmd[7:2] == `LHCI_CMD_PAGE) begin
				page_reg <= cmd[1:0]; // [RULE25]
			end else if (cmd == `LHCI_CMD_RMW) begin
				rmw_reg <= 1'b1;
				saved_col_reg <= col_reg;
			end else if (cmd == `LHCI_CMD_END) begin
				rmw_reg <= 1'b0; // [RULE16]
			end else if (cmd == `LHCI_CMD_RESET) begin
				line_reg <= `LHCI_LINE_RST; // [RULE18]
				page_reg <= `LHCI_PAGE_RST; // [RULE18]
			end
		end
	end

	// column counter; column set is not blocked during rmw, host avoids it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n || pin_edge) begin
			col_reg <= `LHCI_COL_RST; // [RULE23]
		end else if (cmd_end && !cmd[7]) begin
			col_reg <= cmd[6:0]; // [RULE25]
		end else if (cmd_end && cmd == `LHCI_CMD_END && rmw_reg) begin
			col_reg <= saved_col_reg; // [RULE16]
		end else if (wr_end) begin
			col_reg <= next_col(col_reg); // [RULE7] [RULE15] [RULE22]
		end else if (rd_end && !rmw_reg) begin
			col_reg <= next_col(col_reg); // [RULE8] [RULE15] [RULE22]
		end
	end

	// bus holder: writes park here, reads refill it from ram
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			holder_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else begin
			wr_pend_reg <= wr_end && (col_reg < `LHCI_COL_STOP); // [RULE9]
			if (wr_end) begin
				holder_reg <= cyc.data; // [RULE9]
				wr_addr_reg <= ram_idx(page_reg, col_reg); // [RULE7]
			end else if (rd_end) begin
				holder_reg <= rdata_a; // stale until this first read [RULE8]
			end
		end
	end

	// data pins: driven from the holder or status while a read is open
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_data_out <= 8'h00;
			host_data_oe_n <= 1'b1;
		end else if (st_start) begin
			host_data_out <= status; // [RULE1]
			host_data_oe_n <= 1'b0;
		end else if (rd_start) begin
			host_data_out <= holder_reg; // [RULE8]
			host_data_oe_n <= 1'b0;
		end else if (acc_end) begin
			host_data_oe_n <= 1'b1;
		end
	end

	// power save follows the two settings; leaving is automatic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_reg <= 1'b0;
		end else begin
			ps_reg <= ~disp_on_reg & static_reg; // [RULE13] [RULE14]
		end
	end

	// scan lookup with start line and segment order
	assign eff_line = scan_line + line_reg;
	assign scan_col = seg_order_reg ? scan_seg : `LHCI_COL_LAST - scan_seg; // [RULE4]

	// panel-side outputs; static wins over display data, power save over all
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seg_bit <= 1'b0;
			com_all_active <= 1'b0;
			duty_32 <= 1'b1;
			drivers_at_supply <= 1'b0;
			oscillator_output_oe_n <= 1'b0;
		end else begin
			if (ps_reg) begin
				seg_bit <= 1'b0; // [RULE13]
			end else if (static_reg) begin
				seg_bit <= 1'b1; // [RULE12]
			end else begin
				seg_bit <= disp_on_reg & rdata_b[eff_line[2:0]];
			end
			com_all_active <= static_reg & ~ps_reg; // [RULE12]
			duty_32 <= duty_reg;
			drivers_at_supply <= ps_reg; // [RULE13]
			oscillator_output_oe_n <= ps_reg; // floats the pin [RULE13]
		end
	end

	// checks on the design's own behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_data_wr;
		wr_end && col_reg < `LHCI_COL_STOP;
	endsequence
	sequence s_data_rd;
		rd_end && !cmd_end;
	endsequence

	property p_status_byte;
		st_start |=> host_data_out[3:0] == 4'h0 && !host_data_oe_n
			&& host_data_out[4] == $past(resetting_reg) && host_data_out[5] == !$past(disp_on_reg);
	endproperty
	a_status_byte: assert property (p_status_byte) else $error("bad status byte"); // [RULE1]

	property p_busy_after_cmd;
		cmd_end |=> busy [*2];
	endproperty
	a_busy_after_cmd: assert property (p_busy_after_cmd) else $error("busy dropped early"); // [RULE2]

	property p_write_step;
		s_data_wr |=> col_reg == $past(col_reg) + 7'h01 && page_reg == $past(page_reg);
	endproperty
	a_write_step: assert property (p_write_step) else $error("write step wrong"); // [RULE7]

	property p_read_step;
		s_data_rd |=> col_reg == ($past(rmw_reg) ? $past(col_reg) : next_col($past(col_reg)));
	endproperty
	a_read_step: assert property (p_read_step) else $error("read step wrong"); // [RULE15]

	property p_holder_commit;
		s_data_wr |=> wr_pend_reg && holder_reg == $past(cyc.data) ##1 !wr_pend_reg;
	endproperty
	a_holder_commit: assert property (p_holder_commit) else $error("holder commit wrong"); // [RULE9]

	property p_col_limit;
		col_reg == `LHCI_COL_STOP && (wr_end || rd_end) |=> col_reg == `LHCI_COL_STOP;
	endproperty
	a_col_limit: assert property (p_col_limit) else $error("column passed stop"); // [RULE22]

	property p_end_restore;
		cmd_end && cmd == `LHCI_CMD_END && rmw_reg |=> !rmw_reg && col_reg == $past(saved_col_reg);
	endproperty
	a_end_restore: assert property (p_end_restore) else $error("end did not restore"); // [RULE16]

	property p_reset_cmd;
		cmd_end && cmd == `LHCI_CMD_RESET && !pin_edge
			|=> page_reg == `LHCI_PAGE_RST && line_reg == `LHCI_LINE_RST && resetting_reg;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset command wrong"); // [RULE18]

	property p_power_save;
		!disp_on_reg && static_reg ##1 !disp_on_reg && static_reg |=> drivers_at_supply
			&& oscillator_output_oe_n && !seg_bit;
	endproperty
	a_power_save: assert property (p_power_save) else $error("no power save"); // [RULE13]

	property p_static;
		static_reg && disp_on_reg ##1 static_reg && disp_on_reg |=> seg_bit && com_all_active;
	endproperty
	a_static: assert property (p_static) else $error("static not forced"); // [RULE12]

	property p_pin_init;
		pin_edge |=> resetting_reg && !disp_on_reg && col_reg == `LHCI_COL_RST && !rmw_reg;
	endproperty
	a_pin_init: assert property (p_pin_init) else $error("pin init wrong"); // [RULE23]
endmodule // lhci_top

// ---- tb/lhci_host_model.sv ----
`timescale 1ns/100ps
// host processor on the parallel bus; pins move at the falling edge
module lhci_host_model (
	// clock
	input wire logic clk,
	// bus pins toward the device
	output logic reset_pin,
	output logic strobe_e_rd,
	output logic dir_rw_wr,
	output logic register_select,
	output logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out,
	// a busy poll ran out
	output logic hang
);
	logic m68_reg; // bus style in use
	// idle 80 style bus at time zero
	initial begin
		reset_pin = 1'b0;
		strobe_e_rd = 1'b1;
		dir_rw_wr = 1'b1;
		register_select = 1'b0;
		host_data_in = 8'h00;
		hang = 1'b0;
		m68_reg = 1'b0;
	end
	// a pin edge gives the full init and picks the strobe style
	task automatic set_style(input logic s);
		@(negedge clk);
		reset_pin = s;
		m68_reg = s;
		strobe_e_rd = ~s; // idle level of the new strobe
	endtask
	// strobe held 5 clocks, then 4 quiet clocks, so the cycle time is never short
	task automatic access(input logic rs, input logic rd, input logic [7:0] wd,
			output logic [7:0] q);
		@(negedge clk);
		register_select = rs;
		host_data_in = rd ? ~host_data_in : wd; // released bus never shows old value
		dir_rw_wr = rd; // 68 direction and 80 write strobe share the pin
		strobe_e_rd = m68_reg | ~rd;
		repeat (5) @(negedge clk);
		q = host_data_out;
		strobe_e_rd = ~m68_reg;
		dir_rw_wr = dir_rw_wr | ~m68_reg; // 80 write strobe ends with the cycle
		repeat (4) @(negedge clk);
		dir_rw_wr = 1'b1;
		host_data_in = ~host_data_in;
	endtask
	// status byte
	task automatic status(output logic [7:0] q);
		access(1'b0, 1'b1, 8'h00, q);
	endtask
	// display data byte
	task automatic rd(output logic [7:0] q);
		access(1'b1, 1'b1, 8'h00, q);
	endtask
	// poll until busy drops, bounded
	task automatic wait_ready();
		logic [7:0] s;
		int n;
		n = 0;
		do begin
			status(s);
			n++;
		end while (s[7] !== 1'b0 && n < 100);
		if (s[7] !== 1'b0)
			hang = 1'b1;
	endtask
	// instruction, then wait for it to finish
	task automatic cmd(input logic [7:0] c);
		logic [7:0] q;
		access(1'b0, 1'b0, c, q);
		wait_ready();
	endtask
	// data write, then wait for it to finish
	task automatic wr(input logic [7:0] d);
		logic [7:0] q;
		access(1'b1, 1'b0, d, q);
		wait_ready();
	endtask
endmodule // lhci_host_model

// ---- tb/lhci_top_test.sv ----
`timescale 1ns/100ps
// self-checking bench: host model on the bus, bench on the scan side
module lhci_top_test;
	logic clk = 1'b0; // 125 mhz
	logic rst_n; // async, low active
	logic reset_pin, strobe_e_rd, dir_rw_wr, register_select, host_hang;
	logic [7:0] host_data_in, host_data_out;
	logic host_data_oe_n, bus_mode_68, seg_bit, com_all_active, duty_32;
	logic drivers_at_supply, oscillator_output_oe_n;
	logic [4:0] scan_line; // panel line looked up
	logic [6:0] scan_seg; // segment looked up
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] lfsr = 32'h7942; // fixed seed
	logic [7:0] mem [4][80]; // expected ram image, known cells only
	always #4 clk = ~clk;
	// short init so the run stays brief
	lhci_top #(.INIT_CYCLES(20)) dut_u (.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin),
		.strobe_e_rd(strobe_e_rd), .dir_rw_wr(dir_rw_wr), .register_select(register_select),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe_n(host_data_oe_n), .bus_mode_68(bus_mode_68), .scan_line(scan_line),
		.scan_seg(scan_seg), .seg_bit(seg_bit), .com_all_active(com_all_active),
		.duty_32(duty_32), .drivers_at_supply(drivers_at_supply),
		.oscillator_output_oe_n(oscillator_output_oe_n));
	lhci_host_model host_u (.clk(clk), .reset_pin(reset_pin), .strobe_e_rd(strobe_e_rd),
		.dir_rw_wr(dir_rw_wr), .register_select(register_select),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .hang(host_hang));
	// verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one counted compare
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// lfsr step
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic rand8(output logic [7:0] v);
		lfsr = lfsr_next(lfsr);
		v = lfsr[7:0];
	endtask
	// expected status byte, low nibble zero
	function automatic logic [7:0] stat(input logic b, input logic o, input logic f,
			input logic r);
		return {b, o, f, r, 4'h0};
	endfunction
	// page then column
	task automatic addr(input logic [1:0] pg, input logic [6:0] c);
		host_u.cmd({6'h2e, pg});
		host_u.cmd({1'b0, c});
	endtask
	// random writes from the current column; cells past the stop are never stored
	task automatic write_run(input logic [1:0] pg, input logic [6:0] c, input int n);
		logic [7:0] d;
		for (int i = 0; i < n; i++) begin
			rand8(d);
			if (int'(c) + i < 80)
				mem[pg][int'(c) + i] = d;
			host_u.wr(d);
		end
	endtask
	// dummy read first, since the holder is stale, then n compares
	task automatic read_on(input logic [1:0] pg, input logic [6:0] c, input int n);
		logic [7:0] q;
		// the dummy read also shows the pins turning round
		fork
			host_u.rd(q);
			begin
				repeat (6) @(negedge clk);
				check("pins driven", 8'h00, {7'h0, host_data_oe_n});
			end
		join
		check("pins released", 8'h01, {7'h0, host_data_oe_n});
		for (int i = 0; i < n; i++) begin
			host_u.rd(q);
			check("ram data", mem[pg][int'(c) + i], q);
		end
	endtask
	// one pixel of page three through the scan port
	task automatic pix(input logic o, input logic [4:0] st, input logic [6:0] c,
			input logic [2:0] b);
		@(negedge clk);
		scan_line = 5'd24 + {2'h0, b} - st;
		scan_seg = o ? c : 7'd79 - c;
		repeat (3) @(negedge clk);
		check("pixel", {7'h0, mem[3][c][b]}, {7'h0, seg_bit});
	endtask
	// power save and static drive outputs
	task automatic drive_chk(input logic ps, input logic com);
		check("power save", {7'h0, ps}, {7'h0, drivers_at_supply});
		check("osc float", {7'h0, ps}, {7'h0, oscillator_output_oe_n});
		check("commons", {7'h0, com}, {7'h0, com_all_active});
	endtask
	// a poll that ran out ends the run
	always @(posedge host_hang) begin
		error_cnt++;
		stop_test();
	end
	// main sequence, once per bus style
	initial begin
		logic [7:0] r, s;
		logic [1:0] pg;
		logic [4:0] st;
		rst_n = 1'b0;
		scan_line = 5'h00;
		scan_seg = 7'h00;
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		for (int m = 0; m < 2; m++) begin
			host_u.set_style(~m[0]); // 68 style first, then 80
			repeat (2) @(negedge clk);
			host_u.status(s);
			check("init status", stat(1'b1, 1'b0, 1'b1, 1'b1), s);
			check("bus style", {7'h0, ~m[0]}, {7'h0, bus_mode_68});
			check("duty", 8'h01, {7'h0, duty_32});
			host_u.wait_ready();
			host_u.status(s);
			check("idle status", stat(1'b0, 1'b0, 1'b1, 1'b0), s);
			// fill past the column stop; the next page must stay untouched
			rand8(r);
			pg = r[1:0];
			addr(pg + 2'h1, 7'h00);
			write_run(pg + 2'h1, 7'h00, 4);
			addr(pg, 7'h4c);
			write_run(pg, 7'h4c, 6);
			addr(pg, 7'h4c);
			read_on(pg, 7'h4c, 4);
			addr(pg + 2'h1, 7'h00);
			read_on(pg + 2'h1, 7'h00, 4);
			// read-modify-write: reads hold the column, writes advance
			addr(pg + 2'h1, 7'h01);
			host_u.cmd(8'he0);
			host_u.rd(r);
			repeat (2) begin
				host_u.rd(r);
				check("rmw read", mem[pg + 2'h1][1], r);
			end
			write_run(pg + 2'h1, 7'h01, 2);
			host_u.cmd(8'hee); // no column set while the mode was on
			read_on(pg + 2'h1, 7'h01, 3);
			// reset instruction from page one and a random start line
			addr(2'h3, 7'h20);
			write_run(2'h3, 7'h20, 2);
			rand8(r);
			st = r[4:0];
			host_u.cmd({3'h6, st});
			host_u.cmd(8'hb9);
			host_u.access(1'b0, 1'b0, 8'he2, r);
			host_u.status(s);
			check("reset cmd", stat(1'b1, 1'b0, 1'b1, 1'b1), s);
			host_u.wait_ready();
			host_u.cmd(8'h20);
			read_on(2'h3, 7'h20, 2);
			// display on, both segment orders
			host_u.cmd(8'haf);
			for (int o = 0; o < 2; o++) begin
				host_u.cmd({7'h50, ~o[0]}); // d0 low picks normal order
				host_u.status(s);
				check("order", stat(1'b0, o[0], 1'b0, 1'b0), s);
				rand8(r);
				pix(o[0], 5'h00, 7'h20 + {6'h0, r[3]}, r[2:0]);
			end
			host_u.cmd({3'h6, st});
			pix(1'b1, st, 7'h21, r[6:4]);
			// static drive and power save, entered and left both ways
			host_u.cmd(8'ha5);
			drive_chk(1'b0, 1'b1);
			check("static pixel", 8'h01, {7'h0, seg_bit});
			host_u.cmd(8'hae);
			drive_chk(1'b1, 1'b0);
			host_u.status(s);
			check("off flag", stat(1'b0, 1'b1, 1'b1, 1'b0), s);
			host_u.cmd(8'haf);
			drive_chk(1'b0, 1'b1);
			host_u.cmd(8'hae);
			host_u.cmd(8'ha4);
			drive_chk(1'b0, 1'b0);
			host_u.cmd(8'ha5);
			drive_chk(1'b1, 1'b0);
			host_u.cmd(8'ha4);
			host_u.cmd(8'ha8);
			check("duty low", 8'h00, {7'h0, duty_32});
		end
		stop_test();
	end
endmodule // lhci_top_test
